// ### common/fpm_pkg.sv
// Shared constants and types for the frequency / pulse-width meter.
// Assumes one clock domain; every consumer imports the whole package.
package fpm_pkg;
   localparam int CNT_W = 32;
   localparam int STEP_NS = 25;
   localparam int CLK_PERIOD_NS = 100;
   // One counter step per clock; never less than one cycle
   localparam int STEP_CYCLES = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0] COUNT_STEP = 32'h0000_0001;
   localparam logic MODE_FREQ = 1'h0;
   localparam logic MODE_PULSE = 1'h1;
   // Gray order along Disabled, Triggered, Counting, Ready
   typedef enum logic [1:0]
   {
      ST_DISABLED = 2'h0,
      ST_TRIGGERED = 2'h1,
      ST_COUNTING = 2'h3,
      ST_READY = 2'h2
   } fsm_state_t;
   localparam fsm_state_t STATE_RESET = ST_DISABLED;
endpackage : fpm_pkg

// ### common/fpm_cond_if.sv
// Conditioned events from the input stage to the measuring core.
// Assumes both ends share clk_in; all signals are one-cycle or level.
`timescale 1ns/1ns
interface fpm_cond_if;
   logic meas_rise;
   logic meas_fall;
   logic start_evt;
   logic stop_evt;
   logic gate_time_ok;
   logic gate_pulse_ok;
   modport cond
   (
      output meas_rise, meas_fall, start_evt, stop_evt, gate_time_ok, gate_pulse_ok
   );
   modport core
   (
      input meas_rise, meas_fall, start_evt, stop_evt, gate_time_ok, gate_pulse_ok
   );
endinterface : fpm_cond_if

// ### hdl/fpm_counter.sv
// Loadable up/down counter used for the timing and pulse counters.
// Assumes callers never request load and clear together meaningfully.
`timescale 1ns/1ns
module fpm_counter
#(
   parameter int W = 32
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic load_in,
   input wire logic [W-1:0] load_val_in,
   input wire logic inc_in,
   input wire logic dec_in,
   output logic [W-1:0] count_out
);
   import fpm_pkg::*;
   logic [W-1:0] next_count;

   // Clear beats load, load beats stepping
   always_comb
   begin
      next_count = count_out;
      if (clear_in)
         next_count = W'(COUNT_RESET);
      else if (load_in)
         next_count = load_val_in;
      else if (inc_in)
         next_count = count_out + W'(COUNT_STEP);
      else if (dec_in)
         next_count = count_out - W'(COUNT_STEP);
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         count_out <= W'(COUNT_RESET);
      else
         count_out <= next_count;
   end
endmodule : fpm_counter

// ### hdl/fpm_cond.sv
// Input stage: inversion, edge detection, start/stop source and gate.
// Assumes all inputs are synchronous to clk_in.
`timescale 1ns/1ns
module fpm_cond
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic meas_in,
   input wire logic invert_in,
   input wire logic start_src_hw_in,
   input wire logic sw_start_in,
   input wire logic hw_start_in,
   input wire logic start_level_in,
   input wire logic stop_src_hw_in,
   input wire logic sw_stop_in,
   input wire logic hw_stop_in,
   input wire logic stop_level_in,
   input wire logic gate_en_in,
   input wire logic gate_src_hw_in,
   input wire logic sw_gate_in,
   input wire logic hw_gate_in,
   input wire logic gate_active_high_in,
   input wire logic gate_timer_in,
   input wire logic gate_pulses_in,
   fpm_cond_if.cond ev
);
   import fpm_pkg::*;
   logic [2:0] raw;
   logic [2:0] prev;
   logic [2:0] next_prev;
   logic [2:0] rise;
   logic gate_src;
   logic gate_open;

   // Raw sources: inverted input, selected start, selected stop
   assign raw[0] = meas_in ^ invert_in;
   assign raw[1] = start_src_hw_in ? hw_start_in : sw_start_in;
   assign raw[2] = stop_src_hw_in ? hw_stop_in : sw_stop_in;
   assign next_prev = raw;

   // One edge detector per source
   for (genvar i = 0; i < 3; i++)
   begin : g_edge
      assign rise[i] = raw[i] & ~prev[i];
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         prev <= 3'h0;
      else
         prev <= next_prev;
   end

   assign ev.meas_rise = rise[0];
   assign ev.meas_fall = prev[0] & ~raw[0];
   // Level mode keeps asserting; edge mode fires once
   assign ev.start_evt = start_level_in ? raw[1] : rise[1];
   assign ev.stop_evt = stop_level_in ? raw[2] : rise[2];

   // Gate source and polarity, then per-counter application
   assign gate_src = gate_src_hw_in ? hw_gate_in : sw_gate_in;
   assign gate_open = !gate_en_in || (gate_src == gate_active_high_in);
   assign ev.gate_time_ok = gate_open || !gate_timer_in;
   assign ev.gate_pulse_ok = gate_open || !gate_pulses_in;
endmodule : fpm_cond

// ### hdl/freq_pulse_meter.sv
// Frequency and pulse-width meter core with its four-state controller.
// Assumes synchronous control ports held steady by software between runs.
`timescale 1ns/1ns
// Function
// - 32-bit timing counter, one step per 100 ns clock; nominal step is 25 ns.
// - 32-bit counter accumulating measured input pulses.
// - Software picks frequency mode or pulse-width mode.
// - Frequency mode counts rising edges; optional inversion counts falling ones.
// - Counting period programmed by software in timing steps.
// - Start comes from software command or external hardware signal.
// - Start and stop each act on edge or on level.
// - Inactive gate freezes pulse counting and period; may target either counter.
// - Gate source software or external, active level programmable.
// - Result marked available at period end; interrupt if enabled.
// - Pulse-width mode counts clocks between start and stop.
// - Start and stop edges chosen separately: high, low or full period.
// - Pulse-width mode gates identically and may raise the interrupt.
// - Controller has exactly Disabled, Triggered, Counting, Ready.
// - Current state readable at any time.
// - Enable low holds Disabled; enable rising moves to Triggered.
// - Triggered waits for start signal or selected input edge.
// - Start enters Counting: input periods or clock periods counted.
// - Frequency mode ends Counting when the period timer reaches zero.
// - Pulse-width mode ends Counting on the selected stop edge.
// - Single-shot or continuous measurement chosen by software.
module freq_pulse_meter
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic mode_in,
   input wire logic continuous_in,
   input wire logic irq_en_in,
   input wire logic [fpm_pkg::CNT_W-1:0] period_in,
   input wire logic meas_in,
   input wire logic invert_in,
   input wire logic pw_start_fall_in,
   input wire logic pw_stop_fall_in,
   input wire logic start_src_hw_in,
   input wire logic sw_start_in,
   input wire logic hw_start_in,
   input wire logic start_level_in,
   input wire logic stop_src_hw_in,
   input wire logic sw_stop_in,
   input wire logic hw_stop_in,
   input wire logic stop_level_in,
   input wire logic gate_en_in,
   input wire logic gate_src_hw_in,
   input wire logic sw_gate_in,
   input wire logic hw_gate_in,
   input wire logic gate_active_high_in,
   input wire logic gate_timer_in,
   input wire logic gate_pulses_in,
   output fpm_pkg::fsm_state_t state_out,
   output logic result_valid_out,
   output logic irq_out,
   output logic [fpm_pkg::CNT_W-1:0] time_result_out,
   output logic [fpm_pkg::CNT_W-1:0] pulse_result_out
);
   import fpm_pkg::*;

   fsm_state_t state;
   fsm_state_t next_state;
   logic en_q;
   logic next_en_q;
   logic valid;
   logic next_valid;
   logic irq;
   logic next_irq;
   logic [CNT_W-1:0] time_res;
   logic [CNT_W-1:0] next_time_res;
   logic [CNT_W-1:0] pulse_res;
   logic [CNT_W-1:0] next_pulse_res;
   logic [CNT_W-1:0] time_cnt;
   logic [CNT_W-1:0] pulse_cnt;
   logic t_clr;
   logic t_load;
   logic t_inc;
   logic t_dec;
   logic p_clr;
   logic p_inc;
   logic start_cond;
   logic stop_edge;
   logic finish;

   fpm_cond_if ev ();

   // Input conditioning shared by both modes
   fpm_cond u_cond
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .meas_in(meas_in),
      .invert_in(invert_in),
      .start_src_hw_in(start_src_hw_in),
      .sw_start_in(sw_start_in),
      .hw_start_in(hw_start_in),
      .start_level_in(start_level_in),
      .stop_src_hw_in(stop_src_hw_in),
      .sw_stop_in(sw_stop_in),
      .hw_stop_in(hw_stop_in),
      .stop_level_in(stop_level_in),
      .gate_en_in(gate_en_in),
      .gate_src_hw_in(gate_src_hw_in),
      .sw_gate_in(sw_gate_in),
      .hw_gate_in(hw_gate_in),
      .gate_active_high_in(gate_active_high_in),
      .gate_timer_in(gate_timer_in),
      .gate_pulses_in(gate_pulses_in),
      .ev(ev.cond)
   );

   // Timing reference counter: down in frequency, up in pulse width
   fpm_counter #(.W(CNT_W)) u_time
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(t_clr),
      .load_in(t_load),
      .load_val_in(period_in),
      .inc_in(t_inc),
      .dec_in(t_dec),
      .count_out(time_cnt)
   );

   // Input pulse counter
   fpm_counter #(.W(CNT_W)) u_pulse
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(p_clr),
      .load_in(1'h0),
      .load_val_in(COUNT_RESET),
      .inc_in(p_inc),
      .dec_in(1'h0),
      .count_out(pulse_cnt)
   );

   // Start and stop selection per mode
   assign stop_edge = pw_stop_fall_in ? ev.meas_fall : ev.meas_rise;
   always_comb
   begin
      if (mode_in == MODE_FREQ)
         start_cond = ev.start_evt;
      else
         start_cond = pw_start_fall_in ? ev.meas_fall : ev.meas_rise;
   end

   // Next state, counter controls and result latching
   always_comb
   begin
      next_state = state;
      next_en_q = enable_in;
      next_valid = valid;
      next_irq = 1'h0;
      next_time_res = time_res;
      next_pulse_res = pulse_res;
      t_clr = 1'h0;
      t_load = 1'h0;
      t_inc = 1'h0;
      t_dec = 1'h0;
      p_clr = 1'h0;
      p_inc = 1'h0;
      finish = 1'h0;
      case (state)
         ST_DISABLED:
         begin
            if (enable_in && !en_q)
            begin
               next_state = ST_TRIGGERED;
               next_valid = 1'h0;
            end
         end
         ST_TRIGGERED:
         begin
            if (start_cond)
            begin
               next_state = ST_COUNTING;
               p_clr = 1'h1;
               if (mode_in == MODE_FREQ)
                  t_load = 1'h1;
               else
                  t_clr = 1'h1;
            end
         end
         ST_COUNTING:
         begin
            if (mode_in == MODE_FREQ)
            begin
               // Zero period or an explicit stop ends the run at once
               finish = (time_cnt == COUNT_RESET) || ev.stop_evt;
               t_dec = !finish && ev.gate_time_ok;
               p_inc = !finish && ev.gate_pulse_ok && ev.meas_rise;
            end
            else
            begin
               finish = stop_edge;
               t_inc = !finish && ev.gate_time_ok;
            end
            if (finish)
            begin
               next_state = ST_READY;
               next_time_res = time_cnt;
               next_pulse_res = pulse_cnt;
               next_valid = 1'h1;
               next_irq = irq_en_in;
            end
         end
         ST_READY:
         begin
            // Single-shot waits here for a new enable rise
            if (continuous_in)
               next_state = ST_TRIGGERED;
         end
         default:
         begin
            next_state = ST_DISABLED;
         end
      endcase
      if (!enable_in)
         next_state = ST_DISABLED;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state <= STATE_RESET;
         en_q <= 1'h0;
         valid <= 1'h0;
         irq <= 1'h0;
         time_res <= COUNT_RESET;
         pulse_res <= COUNT_RESET;
      end
      else
      begin
         state <= next_state;
         en_q <= next_en_q;
         valid <= next_valid;
         irq <= next_irq;
         time_res <= next_time_res;
         pulse_res <= next_pulse_res;
      end
   end

   // Results stay readable after disable until the next run finishes; the next enable rise clears only the valid flag
   assign state_out = state;
   assign result_valid_out = valid;
   assign irq_out = irq;
   assign time_result_out = time_res;
   assign pulse_result_out = pulse_res;

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_arm;
      state == ST_DISABLED && enable_in && !en_q;
   endsequence

   sequence s_freq_start;
      state == ST_TRIGGERED && enable_in && start_cond && mode_in == MODE_FREQ;
   endsequence

   sequence s_freq_zero;
      state == ST_COUNTING && enable_in && mode_in == MODE_FREQ && time_cnt == COUNT_RESET;
   endsequence

   property p_disabled_hold;
      !enable_in |=> state == ST_DISABLED;
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("state not disabled after enable low");

   property p_arm;
      s_arm |=> state == ST_TRIGGERED ##1 (state != ST_DISABLED || !$past(enable_in));
   endproperty
   a_arm: assert property (p_arm)
      else $error("enable rise did not arm");

   property p_start;
      state == ST_TRIGGERED && enable_in && start_cond |=> state == ST_COUNTING;
   endproperty
   a_start: assert property (p_start)
      else $error("start condition did not enter counting");

   property p_load;
      s_freq_start |=> time_cnt == $past(period_in);
   endproperty
   a_load: assert property (p_load)
      else $error("period not loaded at start");

   property p_freq_done;
      s_freq_zero |=> state == ST_READY && result_valid_out;
   endproperty
   a_freq_done: assert property (p_freq_done)
      else $error("timer zero did not finish");

   property p_pw_done;
      state == ST_COUNTING && enable_in && mode_in == MODE_PULSE && stop_edge
         |=> state == ST_READY && time_result_out == $past(time_cnt);
   endproperty
   a_pw_done: assert property (p_pw_done)
      else $error("stop edge did not finish pulse width");

   property p_irq;
      state == ST_COUNTING && finish && enable_in |=> irq_out == $past(irq_en_in) ##1 !irq_out;
   endproperty
   a_irq: assert property (p_irq)
      else $error("completion interrupt wrong");

   property p_rearm;
      state == ST_READY && enable_in && continuous_in |=> state == ST_TRIGGERED;
   endproperty
   a_rearm: assert property (p_rearm)
      else $error("continuous mode did not rearm");

   property p_single;
      state == ST_READY && enable_in && !continuous_in |=> state == ST_READY;
   endproperty
   a_single: assert property (p_single)
      else $error("single shot left ready");

   property p_gate_freeze;
      state == ST_COUNTING && enable_in && !ev.gate_time_ok && !finish
         |=> time_cnt == $past(time_cnt);
   endproperty
   a_gate_freeze: assert property (p_gate_freeze)
      else $error("timer moved while gated");

   property p_pulse_count;
      state == ST_COUNTING && mode_in == MODE_FREQ && !finish && ev.gate_pulse_ok
         && ev.meas_rise |=> pulse_cnt == $past(pulse_cnt) + COUNT_STEP;
   endproperty
   a_pulse_count: assert property (p_pulse_count)
      else $error("input edge not counted");

   property p_pw_tick;
      state == ST_COUNTING && mode_in == MODE_PULSE && !finish && ev.gate_time_ok
         ##1 state == ST_COUNTING |-> time_cnt == $past(time_cnt) + COUNT_STEP;
   endproperty
   a_pw_tick: assert property (p_pw_tick)
      else $error("pulse width did not count clock");
endmodule : freq_pulse_meter

// ### verif/meas_source.sv
// Model of the measured input: a free-running wave of fixed high and low lengths.
// Assumes it shares clk_in with the meter and changes only just after a rising edge.
`timescale 1ns/1ns
module meas_source
#(
   parameter int HIGH = 3,
   parameter int LOW = 5
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   output logic meas_out
);
   int cnt;
   // Whole-cycle phases keep every window of HIGH+LOW edges at one rise
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         meas_out <= 1'h0;
         cnt <= 0;
      end
      else if (cnt >= (meas_out ? HIGH : LOW) - 1)
      begin
         meas_out <= ~meas_out;
         cnt <= 0;
      end
      else
         cnt <= cnt + 1;
   end
endmodule : meas_source

// ### verif/tb_top.sv
// Self-checking bench for the meter, driving every control port directly.
// Assumes the meas_source wave of 3 high and 5 low cycles on meas_in.
`timescale 1ns/1ns
module tb_top;
   import fpm_pkg::*;
   logic clk_in = 1'h0, rst_in = 1'h1, enable_in = 1'h0, mode_in = 1'h0;
   logic continuous_in = 1'h0, irq_en_in = 1'h0, meas_in, invert_in = 1'h0;
   logic pw_start_fall_in = 1'h0, pw_stop_fall_in = 1'h0, start_src_hw_in = 1'h0;
   logic sw_start_in = 1'h0, hw_start_in = 1'h0, start_level_in = 1'h0;
   logic sw_stop_in = 1'h0, gate_en_in = 1'h0, gate_src_hw_in = 1'h0;
   logic stop_src_hw_in = 1'h0, hw_stop_in = 1'h0, stop_level_in = 1'h0;
   logic sw_gate_in = 1'h0, hw_gate_in = 1'h0, gate_active_high_in = 1'h1;
   logic gate_timer_in = 1'h1, gate_pulses_in = 1'h1, result_valid_out, irq_out;
   logic [CNT_W-1:0] period_in = 32'h0, time_result_out, pulse_result_out;
   fsm_state_t state_out;
   int n_errors = 0, num_checks = 0, cycles = 0;
   freq_pulse_meter u_freq_pulse_meter (.clk_in(clk_in), .rst_in(rst_in),
      .enable_in(enable_in), .mode_in(mode_in), .continuous_in(continuous_in),
      .irq_en_in(irq_en_in), .period_in(period_in), .meas_in(meas_in),
      .invert_in(invert_in), .pw_start_fall_in(pw_start_fall_in),
      .pw_stop_fall_in(pw_stop_fall_in), .start_src_hw_in(start_src_hw_in),
      .sw_start_in(sw_start_in), .hw_start_in(hw_start_in),
      .start_level_in(start_level_in), .stop_src_hw_in(stop_src_hw_in),
      .sw_stop_in(sw_stop_in),
      .hw_stop_in(hw_stop_in), .stop_level_in(stop_level_in), .gate_en_in(gate_en_in),
      .gate_src_hw_in(gate_src_hw_in), .sw_gate_in(sw_gate_in), .hw_gate_in(hw_gate_in),
      .gate_active_high_in(gate_active_high_in), .gate_timer_in(gate_timer_in),
      .gate_pulses_in(gate_pulses_in), .state_out(state_out),
      .result_valid_out(result_valid_out), .irq_out(irq_out),
      .time_result_out(time_result_out), .pulse_result_out(pulse_result_out));
   meas_source u_meas_source (.clk_in(clk_in), .rst_in(rst_in), .meas_out(meas_in));
   // 100 ns period
   always #50 clk_in = ~clk_in;
   // Hang guard: the whole sequence needs well under 1500 cycles
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cs(input fsm_state_t e);
      chk({30'h0, state_out}, {30'h0, e});
   endtask : cs
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // Enable low for one sampled cycle, then high; Triggered one edge later
   task automatic arm();
      @(posedge clk_in) enable_in <= 1'h0;
      @(posedge clk_in) enable_in <= 1'h1;
      @(posedge clk_in);
      @(negedge clk_in);
      cs(ST_TRIGGERED);
      chk(result_valid_out, 1'h0);
   endtask : arm
   task automatic wait_ready(input int lim);
      int i;
      for (i = 0; i < lim && state_out !== ST_READY; i++)
         @(negedge clk_in);
      cs(ST_READY);
   endtask : wait_ready
   // Software start pulse; Counting is checked at the edge that samples it
   task automatic sw_go(input logic [31:0] p);
      period_in <= p;
      @(posedge clk_in) sw_start_in <= 1'h1;
      @(posedge clk_in) sw_start_in <= 1'h0;
      @(negedge clk_in);
      cs(ST_COUNTING);
   endtask : sw_go
   // Ungated run of p cycles: Ready exactly p+1 edges after Counting
   task automatic freq_run(input logic [31:0] p);
      arm();
      sw_go(p);
      repeat (p) @(negedge clk_in);
      cs(ST_COUNTING);
      @(negedge clk_in);
      cs(ST_READY);
      chk(result_valid_out, 1'h1);
      chk(pulse_result_out, p / 8);
      chk(time_result_out, 32'h0);
   endtask : freq_run
   // Pulse-width run; both end cycles are excluded from the count
   task automatic pw_run(input logic sf, tf, inv, input logic [31:0] e);
      mode_in <= MODE_PULSE;
      pw_start_fall_in <= sf;
      pw_stop_fall_in <= tf;
      invert_in <= inv;
      arm();
      wait_ready(40);
      chk(time_result_out, e);
      chk(pulse_result_out, 32'h0);
   endtask : pw_run
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'h0;
      @(negedge clk_in);
      cs(ST_DISABLED);
      chk({result_valid_out, irq_out}, 2'h0);
      chk(time_result_out | pulse_result_out, 32'h0);
      // Single shot with interrupt: one-cycle pulse on entry to Ready
      irq_en_in <= 1'h1;
      freq_run(32'h10);
      chk(irq_out, 1'h1);
      @(negedge clk_in);
      chk(irq_out, 1'h0);
      cs(ST_READY);
      $display("test single frequency done");
      enable_in <= 1'h0;
      @(negedge clk_in);
      cs(ST_DISABLED);
      // Continuous: rearm after Ready, then a held hardware level restarts
      continuous_in <= 1'h1;
      freq_run(32'h18);
      @(negedge clk_in);
      cs(ST_TRIGGERED);
      start_src_hw_in <= 1'h1;
      start_level_in <= 1'h1;
      hw_start_in <= 1'h1;
      @(negedge clk_in);
      cs(ST_COUNTING);
      // The period is still 24 steps, so Ready comes 25 edges after this start
      wait_ready(30);
      @(negedge clk_in);
      cs(ST_TRIGGERED);
      @(negedge clk_in);
      cs(ST_COUNTING);
      hw_start_in <= 1'h0;
      start_src_hw_in <= 1'h0;
      start_level_in <= 1'h0;
      continuous_in <= 1'h0;
      $display("test continuous done");
      // External gate, active low, holds both counters while closed
      gate_en_in <= 1'h1;
      gate_src_hw_in <= 1'h1;
      gate_active_high_in <= 1'h0;
      hw_gate_in <= 1'h1;
      arm();
      sw_go(32'h8);
      repeat (30) @(negedge clk_in);
      cs(ST_COUNTING);
      hw_gate_in <= 1'h0;
      wait_ready(12);
      chk(pulse_result_out, 32'h1);
      // Software gate on the pulse counter only: timer still runs out
      gate_src_hw_in <= 1'h0;
      gate_active_high_in <= 1'h1;
      gate_timer_in <= 1'h0;
      arm();
      sw_go(32'h10);
      wait_ready(18);
      chk(pulse_result_out, 32'h0);
      gate_en_in <= 1'h0;
      gate_timer_in <= 1'h1;
      $display("test gate done");
      // Early software stop leaves time on the period timer
      arm();
      sw_go(32'h64);
      repeat (4) @(posedge clk_in);
      sw_stop_in <= 1'h1;
      @(posedge clk_in) sw_stop_in <= 1'h0;
      // Look only once the edge that samples the stop has settled
      @(negedge clk_in);
      wait_ready(5);
      // Four decrements before the edge that sees the stop
      chk(time_result_out, 32'h60);
      // Held hardware stop level ends the run on the first counting edge
      stop_src_hw_in <= 1'h1;
      stop_level_in <= 1'h1;
      hw_stop_in <= 1'h1;
      arm();
      sw_go(32'h64);
      @(negedge clk_in);
      cs(ST_READY);
      chk(time_result_out, 32'h64);
      stop_src_hw_in <= 1'h0;
      stop_level_in <= 1'h0;
      hw_stop_in <= 1'h0;
      $display("test stop done");
      // High time, low time, period, and high set-up with inversion
      pw_run(1'h0, 1'h1, 1'h0, 32'h2);
      pw_run(1'h1, 1'h0, 1'h0, 32'h4);
      pw_run(1'h0, 1'h0, 1'h0, 32'h7);
      pw_run(1'h0, 1'h1, 1'h1, 32'h4);
      $display("test pulse width done");
      report_and_stop();
   end
endmodule : tb_top
